/* core/p9mux_pkg.sv */
package p9mux_pkg;
  // Pin count of the port
  localparam int unsigned NPIN = 16;
  // Word indices; byte address is four times the index
  localparam logic [29:0] IDX_DRV = 30'h0FFFFC72;
  localparam logic [29:0] IDX_DRV_H = 30'h0FFFFC73;
  localparam logic [29:0] IDX_DATA = 30'h0FFFFC60;
  localparam logic [29:0] IDX_DIR = 30'h0FFFFC61;
  localparam logic [29:0] IDX_MODE = 30'h0FFFFC62;
  localparam logic [29:0] IDX_FSEL = 30'h0FFFFC64;
  localparam logic [29:0] IDX_XSEL = 30'h0FFFFC66;
  // Reset values
  localparam logic [15:0] RST_DRV = 16'h0000;
  localparam logic [15:0] RST_DIR = 16'hFFFF;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  // Only bits 15, 14 and 7..0 of the extension select exist
  localparam logic [15:0] XSEL_MASK = 16'hC0FF;
  // Two-bit select codes {ext_function_select, function_select}
  localparam logic [1:0] SEL_00 = 2'h0;
  localparam logic [1:0] SEL_01 = 2'h1;
  localparam logic [1:0] SEL_10 = 2'h2;
  localparam logic [1:0] SEL_11 = 2'h3;
  // Byte lane positions
  localparam int unsigned LO_MSB = 7;
  localparam int unsigned HI_LSB = 8;
endpackage

/* core/p9mux_pad_if.sv */
`timescale 1ns/1ps
interface p9mux_pad_if;
  logic [15:0] alt_o;   // Alternate function output level
  logic [15:0] alt_oe;  // Alternate function drives the pin
  logic [15:0] alt_en;  // Pin is in alternate mode
  logic [15:0] port_o;  // Port output latch
  logic [15:0] port_oe; // Port direction is output
  logic [15:0] od;      // Open-drain select
  logic [15:0] pad_o;   // Resolved pin level
  logic [15:0] pad_oe;  // Resolved pin enable
  modport core (output alt_o, alt_oe, alt_en, port_o, port_oe, od, input pad_o, pad_oe);
  modport pad (input alt_o, alt_oe, alt_en, port_o, port_oe, od, output pad_o, pad_oe);
endinterface

/* core/p9mux_pad.sv */
`timescale 1ns/1ps
module p9mux_pad (
  p9mux_pad_if.pad pif
);
  genvar k;
  // One driver stage per pin
  generate
    for (k = 0; k < 16; k++) begin : g_pad
      logic lvl;
      logic en;
      // Alternate mode takes the pin away from the port latch
      assign lvl = pif.alt_en[k] ? pif.alt_o[k] : pif.port_o[k];
      assign en = pif.alt_en[k] ? pif.alt_oe[k] : pif.port_oe[k];
      // Open drain only ever pulls low; a high is left to the pull-up
      assign pif.pad_oe[k] = en & (~pif.od[k] | ~lvl);
      assign pif.pad_o[k] = lvl & ~pif.od[k];
    end
  endgenerate
endmodule

/* core/p9mux_tmr_pin.sv */
`timescale 1ns/1ps
module p9mux_tmr_pin (
  input wire logic en,
  input wire logic [1:0] sel,
  input wire logic pin_in,
  input wire logic addr_bit,
  input wire logic tmr_out,
  output logic cap_in,
  output logic alt_o,
  output logic alt_oe
);
  // Address, capture, timer output; the fourth code drives nothing
  always_comb begin
    alt_o = 1'b0;
    alt_oe = 1'b0;
    case (sel)
      p9mux_pkg::SEL_00: begin
        alt_o = addr_bit;
        alt_oe = 1'b1;
      end
      p9mux_pkg::SEL_10: begin
        alt_o = tmr_out;
        alt_oe = 1'b1;
      end
      default: begin
        alt_oe = 1'b0;
      end
    endcase
  end
  // Capture sees the pin only when chosen, else a quiet low
  assign cap_in = (en && sel == p9mux_pkg::SEL_01) ? pin_in : 1'b0;
endmodule

/* core/p9mux_top.sv */
`timescale 1ns/1ps
// Operation
// - Pin 15: addr, irq6, tmr5c0 cap, tmr5c0 out
// - Pin 14: addr, irq5, tmr5c1 cap, tmr5c1 out
// - Pin 13: addr or irq4
// - Pin 12: addr or csi3 clock
// - Pin 11: addr or csi3 data out
// - Pin 10: addr or csi3 data in
// - Pin 9: addr or csi1 clock
// - Pin 8: addr or csi1 data out
// - Pin 7: addr, csi1 in, tmr2c0 cap/out
// - Pin 6: addr, -, tmr2c1 cap/out
// - Pins 2-5: addr, capture, timer output
// - Pin 1: addr, key7, uart rx, clock
// - Pin 0: addr, key6, uart tx, data
// - Drive bit set gives open drain
// - Drive type register resets to zero
// - Drive type: word and byte access
// - High byte view holds bits 8-15
// - Mode bit zero keeps plain port
module p9mux_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] pad_in,
  output logic [15:0] pad_out,
  output logic [15:0] pad_oe,
  input wire logic [15:0] address_bus_out,
  output logic ext_irq4_in,
  output logic ext_irq5_in,
  output logic ext_irq6_in,
  output logic timer5_ch0_capture_in,
  input wire logic timer5_ch0_out,
  output logic timer5_ch1_capture_in,
  input wire logic timer5_ch1_out,
  output logic timer2_ch0_capture_in,
  input wire logic timer2_ch0_out,
  output logic timer2_ch1_capture_in,
  input wire logic timer2_ch1_out,
  output logic timer3_ch0_capture_in,
  input wire logic timer3_ch0_out,
  output logic timer3_ch1_capture_in,
  input wire logic timer3_ch1_out,
  output logic timer4_ch0_capture_in,
  input wire logic timer4_ch0_out,
  output logic timer4_ch1_capture_in,
  input wire logic timer4_ch1_out,
  output logic csi3_serial_clock_in,
  input wire logic csi3_serial_clock_out,
  input wire logic csi3_serial_clock_oe,
  input wire logic csi3_data_out,
  output logic csi3_data_in,
  output logic csi1_serial_clock_in,
  input wire logic csi1_serial_clock_out,
  input wire logic csi1_serial_clock_oe,
  input wire logic csi1_data_out,
  output logic csi1_data_in,
  output logic key_return6_in,
  output logic key_return7_in,
  output logic uart1_receive_in,
  input wire logic uart1_transmit_out,
  output logic two_wire_clock_in,
  input wire logic two_wire_clock_out,
  input wire logic two_wire_clock_oe,
  output logic two_wire_data_in,
  input wire logic two_wire_data_out,
  input wire logic two_wire_data_oe
);
  logic [15:0] data_r;  // Port output latch
  logic [15:0] dir_r;   // One means input
  logic [15:0] mode_r;  // One means alternate function
  logic [15:0] fsel_r;  // function_select bits
  logic [15:0] xsel_r;  // ext_function_select bits
  logic [15:0] drv_r;   // output_drive_type bits
  logic [31:0] rd_r;    // Registered read data
  logic rdy_r;          // Access phase answer
  logic err_r;          // Unmapped address seen in setup
  logic [31:0] rd_nxt;  // Read data before the flop
  logic map_nxt;        // Address decodes to a register
  logic wr_go;          // Write lands this edge
  logic [15:0] wd_lo;   // Low byte write mask
  logic [15:0] wd_hi;   // High byte write mask
  logic [15:0] wdat;    // Write data in register layout
  logic [1:0] sel [16]; // Per-pin select code
  logic [15:0] alt_o;   // Per-pin alternate output
  logic [15:0] alt_oe;  // Per-pin alternate enable
  logic [5:2] g_cap;    // Capture inputs of pins 2-5
  logic [5:2] g_tmr;    // Timer outputs of pins 2-5
  logic [5:2] g_o;      // Generic pin outputs
  logic [5:2] g_oe;     // Generic pin enables

  p9mux_pad_if pif ();

  // True when the current address hits the given word index
  function automatic logic hit(input logic [31:0] a, input logic [29:0] idx);
    return a[31:2] == idx;
  endfunction

  // True when a pin is in alternate mode with the given code
  function automatic logic on(input logic m, input logic [1:0] s, input logic [1:0] c);
    return m && (s == c);
  endfunction

  // Select codes; single-bit pins see zero in the upper bit
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      sel[i] = {xsel_r[i], fsel_r[i]};
    end
  end

  // Read mux and decode for the setup cycle
  always_comb begin
    rd_nxt = 32'h00000000;
    map_nxt = 1'b1;
    if (hit(paddr, p9mux_pkg::IDX_DRV)) begin
      rd_nxt[15:0] = drv_r;
    end else if (hit(paddr, p9mux_pkg::IDX_DRV_H)) begin
      rd_nxt[7:0] = drv_r[15:8];
    end else if (hit(paddr, p9mux_pkg::IDX_DATA)) begin
      // Inputs read the pin, outputs read back the latch
      rd_nxt[15:0] = (dir_r & pad_in) | (~dir_r & data_r);
    end else if (hit(paddr, p9mux_pkg::IDX_DIR)) begin
      rd_nxt[15:0] = dir_r;
    end else if (hit(paddr, p9mux_pkg::IDX_MODE)) begin
      rd_nxt[15:0] = mode_r;
    end else if (hit(paddr, p9mux_pkg::IDX_FSEL)) begin
      rd_nxt[15:0] = fsel_r;
    end else if (hit(paddr, p9mux_pkg::IDX_XSEL)) begin
      rd_nxt[15:0] = xsel_r;
    end else begin
      map_nxt = 1'b0;
    end
  end

  // Answer one cycle after setup: zero wait states, data from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_r <= 1'b0;
      err_r <= 1'b0;
      rd_r <= 32'h00000000;
    end else begin
      rdy_r <= psel & ~penable;
      err_r <= psel & ~penable & ~map_nxt;
      if (psel && !penable && !pwrite) begin
        rd_r <= rd_nxt;
      end
    end
  end

  assign pready = rdy_r;
  assign pslverr = rdy_r & err_r;
  assign prdata = rd_r;

  // A write takes effect only at the completing edge
  assign wr_go = psel & penable & pwrite & rdy_r & ~err_r;
  assign wd_lo = pstrb[0] ? 16'h00FF : 16'h0000;
  assign wd_hi = pstrb[1] ? 16'hFF00 : 16'h0000;
  assign wdat = pwdata[15:0];

  // Drive type: full word or the high byte view at its own index
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_r <= p9mux_pkg::RST_DRV;
    end else if (wr_go && hit(paddr, p9mux_pkg::IDX_DRV)) begin
      drv_r <= (drv_r & ~(wd_lo | wd_hi)) | (wdat & (wd_lo | wd_hi));
    end else if (wr_go && hit(paddr, p9mux_pkg::IDX_DRV_H) && pstrb[0]) begin
      drv_r[15:8] <= pwdata[7:0];
    end
  end

  // Port latch and direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_r <= p9mux_pkg::RST_ZERO;
      dir_r <= p9mux_pkg::RST_DIR;
    end else if (wr_go && hit(paddr, p9mux_pkg::IDX_DATA)) begin
      data_r <= (data_r & ~(wd_lo | wd_hi)) | (wdat & (wd_lo | wd_hi));
    end else if (wr_go && hit(paddr, p9mux_pkg::IDX_DIR)) begin
      dir_r <= (dir_r & ~(wd_lo | wd_hi)) | (wdat & (wd_lo | wd_hi));
    end
  end

  // Mode and select registers; absent extension bits stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= p9mux_pkg::RST_ZERO;
      fsel_r <= p9mux_pkg::RST_ZERO;
      xsel_r <= p9mux_pkg::RST_ZERO;
    end else if (wr_go && hit(paddr, p9mux_pkg::IDX_MODE)) begin
      mode_r <= (mode_r & ~(wd_lo | wd_hi)) | (wdat & (wd_lo | wd_hi));
    end else if (wr_go && hit(paddr, p9mux_pkg::IDX_FSEL)) begin
      fsel_r <= (fsel_r & ~(wd_lo | wd_hi)) | (wdat & (wd_lo | wd_hi));
    end else if (wr_go && hit(paddr, p9mux_pkg::IDX_XSEL)) begin
      xsel_r <= ((xsel_r & ~(wd_lo | wd_hi)) | (wdat & (wd_lo | wd_hi))) & p9mux_pkg::XSEL_MASK;
    end
  end

  // Pins 2-5 share one shape: address, capture, timer output
  assign g_tmr = {timer3_ch0_out, timer3_ch1_out, timer4_ch0_out, timer4_ch1_out};
  genvar gk;
  generate
    for (gk = 2; gk <= 5; gk++) begin : g_tmr_pin
      p9mux_tmr_pin u_pin (
        .en(mode_r[gk]),
        .sel(sel[gk]),
        .pin_in(pad_in[gk]),
        .addr_bit(address_bus_out[gk]),
        .tmr_out(g_tmr[gk]),
        .cap_in(g_cap[gk]),
        .alt_o(g_o[gk]),
        .alt_oe(g_oe[gk])
      );
    end
  endgenerate
  assign {timer3_ch0_capture_in, timer3_ch1_capture_in} = {g_cap[5], g_cap[4]};
  assign {timer4_ch0_capture_in, timer4_ch1_capture_in} = {g_cap[3], g_cap[2]};

  // Output side of the mux; undecoded and input codes leave oe low
  always_comb begin
    alt_o = 16'h0000;
    alt_oe = 16'h0000;
    alt_o[5:2] = g_o;
    alt_oe[5:2] = g_oe;
    // Pin 15
    case (sel[15])
      p9mux_pkg::SEL_00: {alt_o[15], alt_oe[15]} = {address_bus_out[15], 1'b1};
      p9mux_pkg::SEL_11: {alt_o[15], alt_oe[15]} = {timer5_ch0_out, 1'b1};
      default: alt_oe[15] = 1'b0;
    endcase
    // Pin 14
    case (sel[14])
      p9mux_pkg::SEL_00: {alt_o[14], alt_oe[14]} = {address_bus_out[14], 1'b1};
      p9mux_pkg::SEL_11: {alt_o[14], alt_oe[14]} = {timer5_ch1_out, 1'b1};
      default: alt_oe[14] = 1'b0;
    endcase
    // Single-bit pins 13 to 8
    {alt_o[13], alt_oe[13]} = fsel_r[13] ? 2'b00 : {address_bus_out[13], 1'b1};
    if (fsel_r[12]) begin
      {alt_o[12], alt_oe[12]} = {csi3_serial_clock_out, csi3_serial_clock_oe};
    end else begin
      {alt_o[12], alt_oe[12]} = {address_bus_out[12], 1'b1};
    end
    {alt_o[11], alt_oe[11]} = {fsel_r[11] ? csi3_data_out : address_bus_out[11], 1'b1};
    {alt_o[10], alt_oe[10]} = fsel_r[10] ? 2'b00 : {address_bus_out[10], 1'b1};
    if (fsel_r[9]) begin
      {alt_o[9], alt_oe[9]} = {csi1_serial_clock_out, csi1_serial_clock_oe};
    end else begin
      {alt_o[9], alt_oe[9]} = {address_bus_out[9], 1'b1};
    end
    {alt_o[8], alt_oe[8]} = {fsel_r[8] ? csi1_data_out : address_bus_out[8], 1'b1};
    // Pin 7
    case (sel[7])
      p9mux_pkg::SEL_00: {alt_o[7], alt_oe[7]} = {address_bus_out[7], 1'b1};
      p9mux_pkg::SEL_11: {alt_o[7], alt_oe[7]} = {timer2_ch0_out, 1'b1};
      default: alt_oe[7] = 1'b0;
    endcase
    // Pin 6; code 01 is prohibited and stays undriven
    case (sel[6])
      p9mux_pkg::SEL_00: {alt_o[6], alt_oe[6]} = {address_bus_out[6], 1'b1};
      p9mux_pkg::SEL_11: {alt_o[6], alt_oe[6]} = {timer2_ch1_out, 1'b1};
      default: alt_oe[6] = 1'b0;
    endcase
    // Pin 1; the clock drives only on the peripheral's own enable
    case (sel[1])
      p9mux_pkg::SEL_00: {alt_o[1], alt_oe[1]} = {address_bus_out[1], 1'b1};
      p9mux_pkg::SEL_11: {alt_o[1], alt_oe[1]} = {two_wire_clock_out, two_wire_clock_oe};
      default: alt_oe[1] = 1'b0;
    endcase
    // Pin 0
    case (sel[0])
      p9mux_pkg::SEL_00: {alt_o[0], alt_oe[0]} = {address_bus_out[0], 1'b1};
      p9mux_pkg::SEL_10: {alt_o[0], alt_oe[0]} = {uart1_transmit_out, 1'b1};
      p9mux_pkg::SEL_11: {alt_o[0], alt_oe[0]} = {two_wire_data_out, two_wire_data_oe};
      default: alt_oe[0] = 1'b0;
    endcase
  end

  // Input side: a function not selected sees its idle level
  assign ext_irq6_in = on(mode_r[15], sel[15], p9mux_pkg::SEL_01) & pad_in[15];
  assign timer5_ch0_capture_in = on(mode_r[15], sel[15], p9mux_pkg::SEL_10) & pad_in[15];
  assign ext_irq5_in = on(mode_r[14], sel[14], p9mux_pkg::SEL_01) & pad_in[14];
  assign timer5_ch1_capture_in = on(mode_r[14], sel[14], p9mux_pkg::SEL_10) & pad_in[14];
  assign ext_irq4_in = mode_r[13] & fsel_r[13] & pad_in[13];
  assign csi3_serial_clock_in = (mode_r[12] & fsel_r[12]) ? pad_in[12] : 1'b1;
  assign csi3_data_in = (mode_r[10] & fsel_r[10]) ? pad_in[10] : 1'b1;
  assign csi1_serial_clock_in = (mode_r[9] & fsel_r[9]) ? pad_in[9] : 1'b1;
  assign csi1_data_in = on(mode_r[7], sel[7], p9mux_pkg::SEL_01) ? pad_in[7] : 1'b1;
  assign timer2_ch0_capture_in = on(mode_r[7], sel[7], p9mux_pkg::SEL_10) & pad_in[7];
  assign timer2_ch1_capture_in = on(mode_r[6], sel[6], p9mux_pkg::SEL_10) & pad_in[6];
  // Code 10 feeds both receivers; software keeps one of them idle
  assign key_return7_in = (on(mode_r[1], sel[1], p9mux_pkg::SEL_01) |
                           on(mode_r[1], sel[1], p9mux_pkg::SEL_10)) ? pad_in[1] : 1'b1;
  assign uart1_receive_in = on(mode_r[1], sel[1], p9mux_pkg::SEL_10) ? pad_in[1] : 1'b1;
  assign two_wire_clock_in = on(mode_r[1], sel[1], p9mux_pkg::SEL_11) ? pad_in[1] : 1'b1;
  assign key_return6_in = on(mode_r[0], sel[0], p9mux_pkg::SEL_01) ? pad_in[0] : 1'b1;
  assign two_wire_data_in = on(mode_r[0], sel[0], p9mux_pkg::SEL_11) ? pad_in[0] : 1'b1;

  // Hand the per-pin intent to the pad stage
  assign pif.alt_o = alt_o;
  assign pif.alt_oe = alt_oe;
  assign pif.alt_en = mode_r;
  assign pif.port_o = data_r;
  assign pif.port_oe = ~dir_r;
  assign pif.od = drv_r;
  assign pad_out = pif.pad_o;
  assign pad_oe = pif.pad_oe;

  p9mux_pad u_pad (
    .pif(pif.pad)
  );

  // Checks
  a_drv_reset: assert property (@(posedge pclk) $rose(presetn) |-> drv_r == 16'h0000)
    else $error("drive type not zero after reset");
  a_port_mode: assert property (@(posedge pclk) disable iff (!presetn)
    !mode_r[3] && !dir_r[3] |-> pad_oe[3] == (!drv_r[3] || !data_r[3]))
    else $error("port mode pin not following latch");
  a_od_high: assert property (@(posedge pclk) disable iff (!presetn)
    drv_r[8] |-> !pad_out[8])
    else $error("open drain pin driven high");
  a_pin6_prohib: assert property (@(posedge pclk) disable iff (!presetn)
    mode_r[6] && sel[6] == 2'h1 |-> !pad_oe[6])
    else $error("prohibited code drives pin 6");
  a_pin4_prohib: assert property (@(posedge pclk) disable iff (!presetn)
    mode_r[4] && sel[4] == 2'h3 |-> !pad_oe[4] && !timer3_ch1_capture_in)
    else $error("prohibited code drives pin 4");
  a_pin15_addr: assert property (@(posedge pclk) disable iff (!presetn)
    mode_r[15] && sel[15] == 2'h0 && !drv_r[15] |-> pad_oe[15] && pad_out[15] == address_bus_out[15])
    else $error("pin 15 address route wrong");
  a_pin14_tmr: assert property (@(posedge pclk) disable iff (!presetn)
    mode_r[14] && sel[14] == 2'h2 |-> timer5_ch1_capture_in == pad_in[14] && !pad_oe[14])
    else $error("pin 14 capture route wrong");
  a_pin1_rx: assert property (@(posedge pclk) disable iff (!presetn)
    mode_r[1] && sel[1] == 2'h2 |-> uart1_receive_in == pad_in[1] && key_return7_in == pad_in[1])
    else $error("pin 1 receive route wrong");
  a_pin0_tx: assert property (@(posedge pclk) disable iff (!presetn)
    mode_r[0] && sel[0] == 2'h2 && !drv_r[0] |-> pad_out[0] == uart1_transmit_out)
    else $error("pin 0 transmit route wrong");
  a_hview_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_go && hit(paddr, p9mux_pkg::IDX_DRV_H) && pstrb[0] |=> drv_r[15:8] == $past(pwdata[7:0]))
    else $error("high byte view write lost");
  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready || (psel && !penable))
    else $error("bus answer timing wrong");
  c_addr_bus: cover property (@(posedge pclk) disable iff (!presetn) mode_r == 16'hFFFF && fsel_r == 16'h0000);
  c_open_drain: cover property (@(posedge pclk) disable iff (!presetn) drv_r[0] && mode_r[0] && sel[0] == 2'h3);
  c_key7: cover property (@(posedge pclk) disable iff (!presetn) mode_r[1] && sel[1] == 2'h1);
  c_slverr: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule

/* verification/p9mux_pin_model.sv */
`timescale 1ns/1ps
// Board side of port 9: outside drivers and pull-up resistors on the pins
module p9mux_pin_model (
  input wire logic [15:0] pad_out,
  input wire logic [15:0] pad_oe,
  input wire logic [15:0] ext_lvl, // Level an outside driver puts on a free pin
  input wire logic [15:0] pull_up, // Pins wired to a pull-up resistor
  output logic [15:0] pad_in
);
  // A driven pin reads back its own level; a released one floats to its pull-up or outside driver
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (pull_up[i]) begin
        pad_in[i] = 1'b1;
      end else begin
        pad_in[i] = ext_lvl[i];
      end
    end
  end
endmodule

/* verification/p9mux_top_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module p9mux_top_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB master side
  logic pready, pslverr, er;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd_v, seed, ex;
  logic [3:0] pstrb = 4'h0;
  logic [15:0] pad_in, pad_out, pad_oe, abus = 16'h0, ext = 16'h0, od = 16'h0; // Pins and board
  logic [18:0] pv = 19'h0; // Peripheral drive levels
  logic [19:0] pi; // Peripheral receive levels
  int n_errors = 0, total_checks = 0;

  p9mux_top p9mux_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .address_bus_out(abus),
    .ext_irq4_in(pi[10]), .ext_irq5_in(pi[11]), .ext_irq6_in(pi[12]),
    .timer5_ch0_capture_in(pi[9]), .timer5_ch0_out(pv[0]), .timer5_ch1_capture_in(pi[8]), .timer5_ch1_out(pv[1]),
    .timer2_ch0_capture_in(pi[7]), .timer2_ch0_out(pv[2]), .timer2_ch1_capture_in(pi[6]), .timer2_ch1_out(pv[3]),
    .timer3_ch0_capture_in(pi[5]), .timer3_ch0_out(pv[4]), .timer3_ch1_capture_in(pi[13]), .timer3_ch1_out(pv[5]),
    .timer4_ch0_capture_in(pi[14]), .timer4_ch0_out(pv[6]), .timer4_ch1_capture_in(pi[15]), .timer4_ch1_out(pv[7]),
    .csi3_serial_clock_in(pi[16]), .csi3_serial_clock_out(pv[8]), .csi3_serial_clock_oe(pv[9]),
    .csi3_data_out(pv[10]), .csi3_data_in(pi[0]), .csi1_serial_clock_in(pi[17]), .csi1_serial_clock_out(pv[11]),
    .csi1_serial_clock_oe(pv[12]), .csi1_data_out(pv[13]), .csi1_data_in(pi[1]), .key_return6_in(pi[2]),
    .key_return7_in(pi[4]), .uart1_receive_in(pi[3]), .uart1_transmit_out(pv[14]), .two_wire_clock_in(pi[18]),
    .two_wire_clock_out(pv[15]), .two_wire_clock_oe(pv[16]), .two_wire_data_in(pi[19]), .two_wire_data_out(pv[17]),
    .two_wire_data_oe(pv[18]));
  // Pull-ups sit exactly on the open-drain pins
  p9mux_pin_model p9mux_pin_model_i (.pad_out(pad_out), .pad_oe(pad_oe), .ext_lvl(ext), .pull_up(od),
    .pad_in(pad_in));

  // Free-running bus clock
  initial begin
    forever #20 pclk = ~pclk;
  end

  // Xorshift source, repeatable from the fixed seed
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected pin {enable, level} for select code c on every pin
  function automatic logic [31:0] exp_pins(input logic [1:0] c);
    logic [15:0] o, e;
    o = abus;
    e = 16'h0;
    if (!c[0]) begin
      e[13:8] = 6'h3F;
    end else begin
      e[12:11] = {pv[9], 1'b1};
      o[12:11] = {pv[8], pv[10]};
      e[9:8] = {pv[12], 1'b1};
      o[9:8] = {pv[11], pv[13]};
    end
    case (c)
      2'h0: e = e | 16'hC0FF;
      2'h2: begin
        e[5:0] = 6'h3D;
        o[5:0] = {pv[4], pv[5], pv[6], pv[7], 1'b0, pv[14]};
      end
      2'h3: begin
        e[15:14] = 2'h3;
        o[15:14] = {pv[0], pv[1]};
        e[7:6] = 2'h3;
        o[7:6] = {pv[2], pv[3]};
        e[1:0] = {pv[16], pv[18]};
        o[1:0] = {pv[15], pv[17]};
      end
      default: e = e;
    endcase
    // Open drain releases a high level instead of driving it
    e = e & ~(od & o);
    return {e, o};
  endfunction

  // Expected peripheral receive levels; a selected input sees what stands on its pin, the rest their idle level
  function automatic logic [19:0] exp_in(input logic [1:0] c);
    logic [19:0] v;
    logic [31:0] p;
    logic [15:0] x;
    p = exp_pins(c);
    // A driven pin reads its own level, a released one its pull-up or outside level
    x = (p[31:16] & p[15:0]) | (~p[31:16] & (ext | od));
    v = 20'hF001F;
    if (c[0]) begin
      v[10] = x[13];
      v[0] = x[10];
      v[17:16] = {x[9], x[12]};
    end
    if (c == 2'h1) begin
      v[12:11] = x[15:14];
      v[5:4] = {x[5], x[1]};
      v[2:1] = {x[0], x[7]};
      v[15:13] = {x[2], x[3], x[4]};
    end else if (c == 2'h2) begin
      v[9:6] = {x[15:14], x[7:6]};
      v[4:3] = {x[1], x[1]};
    end else if (c == 2'h3) begin
      v[19:18] = {x[0], x[1]};
    end
    return v;
  endfunction

  // One APB transfer; the request holds until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [29:0] idx, input logic [31:0] wd, input logic [3:0] st);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    // Values read here are those the flops show at this edge, before they move
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("[ERR] pready exp 1 got 0");
      complete_run();
    end
    // Answer taken at the completing edge, then the request is released
    rd_v = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read and compare data and error response
  task automatic rdc(input logic [29:0] idx, input logic [31:0] e, input logic ee);
    apb(1'b0, idx, 32'h0, 4'h0);
    `CHK("prdata", e, rd_v)
    `CHK("pslverr", ee, er)
  endtask

  // Random open-drain pattern, with matching pull-ups on the board
  task automatic set_od();
    ex = rnd();
    od <= ex[15:0];
    apb(1'b1, p9mux_pkg::IDX_DRV, {16'h0, ex[15:0]}, 4'hF);
  endtask

  // Print the counts and the verdict, then stop
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    seed = 32'h109E;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc(p9mux_pkg::IDX_DRV, 32'h0, 1'b0);
    ex = rnd();
    apb(1'b1, p9mux_pkg::IDX_DRV, ex, 4'hF);
    rdc(p9mux_pkg::IDX_DRV, {16'h0, ex[15:0]}, 1'b0);
    rdc(p9mux_pkg::IDX_DRV_H, {24'h0, ex[15:8]}, 1'b0);
    apb(1'b1, p9mux_pkg::IDX_DRV_H, 32'h000000A5, 4'h1);
    apb(1'b1, p9mux_pkg::IDX_DRV, 32'hFFFF3C3C, 4'h1);
    rdc(p9mux_pkg::IDX_DRV, 32'h0000A53C, 1'b0);
    // An unmapped read answers with an error and zero data
    rdc(30'h0FFFFC7F, 32'h00000000, 1'b1);
    // Plain port mode with every pin an output
    set_od();
    ex = rnd();
    apb(1'b1, p9mux_pkg::IDX_DATA, ex, 4'hF);
    apb(1'b1, p9mux_pkg::IDX_DIR, 32'h0, 4'hF);
    @(negedge pclk);
    `CHK("port_oe", ~(od & ex[15:0]), pad_oe)
    `CHK("port_out", ex[15:0] & ~od, pad_out & ~od)
    apb(1'b1, p9mux_pkg::IDX_FSEL, 32'h0, 4'hF);
    apb(1'b1, p9mux_pkg::IDX_XSEL, 32'h0, 4'hF);
    apb(1'b1, p9mux_pkg::IDX_MODE, 32'h0000FFFF, 4'hF);
    // Every select code on all pins at once, with random traffic
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, p9mux_pkg::IDX_FSEL, {16'h0, {16{c[0]}}}, 4'hF);
      apb(1'b1, p9mux_pkg::IDX_XSEL, {16'h0, {16{c[1]}}}, 4'hF);
      set_od();
      repeat (8) begin
        @(posedge pclk);
        pv <= 19'(rnd());
        ext <= 16'(rnd());
        abus <= 16'(rnd());
        @(negedge pclk);
        ex = exp_pins(c[1:0]);
        `CHK("pad_oe", ex[31:16], pad_oe)
        `CHK("pad_out", ex[15:0] & ex[31:16], pad_out & ex[31:16])
        `CHK("periph_in", exp_in(c[1:0]), pi)
      end
    end
    complete_run();
  end
endmodule
